// ===== rtl/vme_irq_pkg.sv
package vme_irq_pkg;
    // Register byte offsets on the Avalon-MM slave
    localparam logic [7:0] OFS_IVEC    = 8'h00; // interrupter_vector_reg
    localparam logic [7:0] OFS_VEN     = 8'h04; // vme_irq_enable
    localparam logic [7:0] OFS_VSTAT   = 8'h08; // vme_irq_status
    localparam logic [7:0] OFS_VMAP    = 8'h0C; // local line to VMEbus level map
    localparam logic [7:0] OFS_PEN     = 8'h10; // pci_irq_enable
    localparam logic [7:0] OFS_PSTAT   = 8'h14; // pci_irq_status
    localparam logic [7:0] OFS_PMAP    = 8'h18; // pci_level_mapping
    localparam logic [7:0] OFS_PMISC   = 8'h1C; // misc source to PCI line map
    localparam logic [7:0] OFS_MCTL    = 8'h20; // master_control
    localparam logic [7:0] OFS_AMERR   = 8'h24; // am_error_log
    localparam logic [7:0] OFS_ERRADR  = 8'h28; // master error address log
    localparam logic [7:0] OFS_LVEC    = 8'h40; // level vectors at base plus 4 * level
    // Field positions
    localparam int SOFT_BASE  = 7;   // per_level_soft_irq level l at bit SOFT_BASE+l
    localparam int PS_SYSFAIL = 8;
    localparam int PS_ACFAIL  = 9;
    localparam int PS_SOFTACK = 10;
    localparam int PS_BERR    = 11;
    localparam int MCTL_SYSCON = 2;
    localparam int LVEC_ERR   = 8;
    localparam int MAP_W      = 3;
    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [6:0]  RST_IVEC = 7'h7F;
    // Command code logged for an acknowledge cycle
    localparam logic [1:0]  CMD_ACK_CYCLE_ERROR_FLAG = 2'h3;
endpackage

// ===== rtl/vme_pci_interrupt_channel.sv
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
// Summary of operation
// - Common 8-bit vector, upper seven programmable
// - Vector bit zero clear for software source
// - Software source answers its level first
// - Soft acknowledge event after software vector
// - Software interrupt released on acknowledge
// - Other interrupts held until status cleared
// - Active local line keeps status set
// - Enabled local lines raise VMEbus interrupt
// - Watch levels and fail lines, no acknowledge
// - Enabled level requests master at level
// - Interrupt channel wins shared master
// - First detected level acknowledged first
// - Forward to PCI only after acknowledge
// - Vector stored per acknowledged level
// - No reacknowledge until status cleared
// - Mapped PCI output until status cleared
// - Bus error logs and error event
// - Failed fetch still completes with flag
// - Soft level bits drive same level
// - Answer only own level with daisy chain
// - Mapping zero never drives a level
module vme_pci_interrupt_channel #(
    parameter int NUM_LINES = 8
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic [7:0]  localIrqLines,
    input  wire logic [7:1]  vmeIrqIn,
    input  wire logic        sysfailIn,
    input  wire logic        acfailIn,
    input  wire logic        iackDecoded,
    input  wire logic [2:0]  iackLevelIn,
    input  wire logic        iackinN,
    output logic      [7:1]  vmeIrqOut,
    output logic      [7:0]  vectorOut,
    output logic             vectorStrobe,
    input  wire logic        targetReq,
    input  wire logic        dmaReq,
    output logic             grantTarget,
    output logic             grantDma,
    output logic             masterReq,
    output logic      [1:0]  busReqLevel,
    output logic             iackStart,
    output logic      [2:0]  iackLevelOut,
    input  wire logic        iackDone,
    input  wire logic        iackBerr,
    input  wire logic [7:0]  iackVectorIn,
    output logic      [7:0]  pciIrqOut
);
    initial begin
        if (NUM_LINES != 8) $error("NUM_LINES must be 8");
    end

    typedef enum logic [1:0] {H_IDLE, H_WAIT, H_ACK_CYCLE_ERROR_FLAG} hstate_e;

    logic [6:0]  ivec_q;
    logic [14:0] vEn_q;
    logic [14:0] vStat_q;
    logic [23:0] vMap_q;
    logic [11:0] pEn_q;
    logic [11:0] pStat_q;
    logic [23:0] pMap_q;
    logic [11:0] pMisc_q;
    logic [2:0]  mctl_q;
    logic        amErr_q;
    logic [4:0]  errAdr_q;
    logic [8:0]  lvec_q [1:7];
    logic [21:0] sync1_q;
    logic [21:0] sync2_q;
    logic        iackPrev_q;
    logic        ack_q;
    logic [31:0] readdata_q;
    logic [7:1]  vmeIrqOut_q;
    logic [7:0]  vectorOut_q;
    logic        vectorStrobe_q;
    logic [2:0]  respLvl_q;
    logic        grantTarget_q;
    logic        grantDma_q;
    logic        grantIrq_q;
    logic        masterReq_q;
    logic        iackStart_q;
    logic [2:0]  curLevel_q;
    logic [7:0]  pciIrqOut_q;
    hstate_e     hstate_q;

    logic [7:0]  localSync;
    logic [7:1]  vmeIrqSync;
    logic        sysfailSync;
    logic        acfailSync;
    logic        iackSync;
    logic        iackinNSync;
    logic [2:0]  iackLvlSync;
    logic        wrAck;
    logic [31:0] wMask;
    logic        iackHit;
    logic        softHit;
    logic        softAckEv;
    logic        hDone;
    logic [7:1]  eligible;

    // Byte enables to a bit mask for partial writes
    function automatic logic [31:0] laneMask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // Highest set bit of a level vector, zero when none
    function automatic logic [2:0] topLevel(input logic [7:1] lv);
        logic [2:0] r;
        r = 3'h0;
        for (int l = 1; l <= 7; l++) begin
            if (lv[l]) r = 3'(l);
        end
        return r;
    endfunction

    // Pins cross in two flops; only the second stage is read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 22'h0;
            sync2_q <= 22'h0;
        end else begin
            sync1_q <= {iackLevelIn, iackinN, iackDecoded, acfailIn, sysfailIn,
                        vmeIrqIn, localIrqLines};
            sync2_q <= sync1_q;
        end
    end

    assign localSync   = sync2_q[7:0];
    assign vmeIrqSync  = sync2_q[14:8];
    assign sysfailSync = sync2_q[15];
    assign acfailSync  = sync2_q[16];
    assign iackSync    = sync2_q[17];
    assign iackinNSync = sync2_q[18];
    assign iackLvlSync = sync2_q[21:19];
    assign wrAck       = write && ack_q;
    assign wMask       = writedata & laneMask(byteenable);

    // Bus answer: waitrequest drops for one cycle, one cycle after request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read || write) && !ack_q;
        end
    end

    // Read data registered in the answering cycle; unmapped reads zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata_q <= vme_irq_pkg::RST_ZERO;
        end else begin
            readdata_q <= vme_irq_pkg::RST_ZERO;
            if (read && !ack_q) begin
                case (address)
                    vme_irq_pkg::OFS_IVEC:   readdata_q <= {24'h0, ivec_q, 1'b0};
                    vme_irq_pkg::OFS_VEN:    readdata_q <= {17'h0, vEn_q};
                    vme_irq_pkg::OFS_VSTAT:  readdata_q <= {17'h0, vStat_q};
                    vme_irq_pkg::OFS_VMAP:   readdata_q <= {8'h0, vMap_q};
                    vme_irq_pkg::OFS_PEN:    readdata_q <= {20'h0, pEn_q};
                    vme_irq_pkg::OFS_PSTAT:  readdata_q <= {20'h0, pStat_q};
                    vme_irq_pkg::OFS_PMAP:   readdata_q <= {8'h0, pMap_q};
                    vme_irq_pkg::OFS_PMISC:  readdata_q <= {20'h0, pMisc_q};
                    vme_irq_pkg::OFS_MCTL:   readdata_q <= {29'h0, mctl_q};
                    vme_irq_pkg::OFS_AMERR:  readdata_q <= {31'h0, amErr_q};
                    vme_irq_pkg::OFS_ERRADR: readdata_q <= {27'h0, errAdr_q};
                    default: begin
                        for (int l = 1; l <= 7; l++) begin
                            if (address == vme_irq_pkg::OFS_LVEC + 8'(4 * l))
                                readdata_q <= {23'h0, lvec_q[l]};
                        end
                    end
                endcase
            end
        end
    end

    // Plain read/write configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ivec_q  <= vme_irq_pkg::RST_IVEC;
            vEn_q   <= 15'h0;
            vMap_q  <= 24'h0;
            pEn_q   <= 12'h0;
            pMap_q  <= 24'h0;
            pMisc_q <= 12'h0;
            mctl_q  <= 3'h0;
        end else if (wrAck) begin
            case (address)
                vme_irq_pkg::OFS_IVEC:  ivec_q  <= wMask[7:1];
                vme_irq_pkg::OFS_VEN:   vEn_q   <= wMask[14:0];
                vme_irq_pkg::OFS_VMAP:  vMap_q  <= wMask[23:0];
                vme_irq_pkg::OFS_PEN:   pEn_q   <= wMask[11:0];
                vme_irq_pkg::OFS_PMAP:  pMap_q  <= wMask[23:0];
                vme_irq_pkg::OFS_PMISC: pMisc_q <= wMask[11:0];
                vme_irq_pkg::OFS_MCTL:  mctl_q  <= wMask[2:0];
                default: ;
            endcase
        end
    end

    // Interrupter acknowledge decode on the synchronised cycle start
    // own level and daisy chain
    assign iackHit   = iackSync && !iackPrev_q && (iackLvlSync != 3'h0)
                       && vmeIrqOut_q[iackLvlSync]
                       && (mctl_q[vme_irq_pkg::MCTL_SYSCON] || !iackinNSync);
    assign softHit   = vStat_q[vme_irq_pkg::SOFT_BASE + int'(iackLvlSync)];
    assign softAckEv = iackHit && softHit;

    // VMEbus interrupt status: set beats software clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vStat_q    <= 15'h0;
            iackPrev_q <= 1'b0;
        end else begin
            iackPrev_q <= iackSync;
            for (int i = 0; i < 8; i++) begin
                // RORA clear, held while line active
                if (wrAck && address == vme_irq_pkg::OFS_VSTAT && wMask[i])
                    vStat_q[i] <= 1'b0;
                if (localSync[i] && vEn_q[i])
                    vStat_q[i] <= 1'b1;
            end
            for (int l = 1; l <= 7; l++) begin
                if (softAckEv && int'(iackLvlSync) == l)
                    vStat_q[vme_irq_pkg::SOFT_BASE + l] <= 1'b0;
                // Rising write of the soft bit triggers one interrupt
                if (wrAck && address == vme_irq_pkg::OFS_VEN
                    && wMask[vme_irq_pkg::SOFT_BASE + l]
                    && !vEn_q[vme_irq_pkg::SOFT_BASE + l])
                    vStat_q[vme_irq_pkg::SOFT_BASE + l] <= 1'b1;
            end
        end
    end

    // Level drive, one cycle behind status; a soft acknowledge drops its level in the same cycle unless a local status mapped there holds it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vmeIrqOut_q <= 7'h0;
        end else begin
            for (int l = 1; l <= 7; l++) begin
                vmeIrqOut_q[l] <= vStat_q[vme_irq_pkg::SOFT_BASE + l]
                                  && !(softAckEv && int'(iackLvlSync) == l);
                // map zero never matches a level
                for (int i = 0; i < 8; i++) begin
                    if (vStat_q[i] && vMap_q[i*3 +: 3] == 3'(l))
                        vmeIrqOut_q[l] <= 1'b1;
                end
            end
        end
    end

    // Vector answer to the VMEbus handler
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vectorOut_q    <= 8'h0;
            vectorStrobe_q <= 1'b0;
            respLvl_q      <= 3'h0;
        end else begin
            vectorStrobe_q <= iackHit;
            if (iackHit) begin
                // common vector, bit zero marks source
                vectorOut_q <= {ivec_q, !softHit};
                respLvl_q   <= iackLvlSync;
            end
        end
    end

    // Shared master arbiter; owner keeps it until its request drops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            grantTarget_q <= 1'b0;
            grantDma_q    <= 1'b0;
            grantIrq_q    <= 1'b0;
        end else if (!grantTarget_q && !grantDma_q && !grantIrq_q) begin
            grantIrq_q    <= masterReq_q;
            grantDma_q    <= !masterReq_q && dmaReq;
            grantTarget_q <= !masterReq_q && !dmaReq && targetReq;
        end else begin
            grantIrq_q    <= grantIrq_q && masterReq_q;
            grantDma_q    <= grantDma_q && dmaReq;
            grantTarget_q <= grantTarget_q && targetReq;
        end
    end

    // enabled, not yet serviced levels only
    assign eligible = vmeIrqSync & pEn_q[7:1] & ~pStat_q[7:1];
    assign hDone    = (hstate_q == H_ACK_CYCLE_ERROR_FLAG) && iackDone;

    // Handler sequence: latch a level, win the master, run the cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hstate_q    <= H_IDLE;
            masterReq_q <= 1'b0;
            iackStart_q <= 1'b0;
            curLevel_q  <= 3'h0;
        end else begin
            iackStart_q <= 1'b0;
            case (hstate_q)
                H_IDLE: begin
                    if (|eligible) begin
                        curLevel_q  <= topLevel(eligible);
                        masterReq_q <= 1'b1;
                        hstate_q    <= H_WAIT;
                    end
                end
                H_WAIT: begin
                    if (grantIrq_q) begin
                        iackStart_q <= 1'b1;
                        hstate_q    <= H_ACK_CYCLE_ERROR_FLAG;
                    end
                end
                H_ACK_CYCLE_ERROR_FLAG: begin
                    if (iackDone) begin
                        masterReq_q <= 1'b0;
                        hstate_q    <= H_IDLE;
                    end
                end
                default: hstate_q <= H_IDLE;
            endcase
        end
    end

    // Stored vectors and error logs on cycle completion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int l = 1; l <= 7; l++) lvec_q[l] <= 9'h0;
            amErr_q  <= 1'b0;
            errAdr_q <= 5'h0;
        end else begin
            if (wrAck && address == vme_irq_pkg::OFS_AMERR && wMask[0])
                amErr_q <= 1'b0;
            if (hDone) begin
                // store per level with error flag
                lvec_q[curLevel_q] <= {iackBerr, iackVectorIn};
                if (iackBerr) begin
                    amErr_q  <= 1'b1;
                    errAdr_q <= {vme_irq_pkg::CMD_ACK_CYCLE_ERROR_FLAG, curLevel_q};
                end
            end
        end
    end

    // PCI status: hardware set wins over write-one clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pStat_q <= 12'h0;
        end else begin
            if (wrAck && address == vme_irq_pkg::OFS_PSTAT)
                pStat_q <= pStat_q & ~wMask[11:0];
            if (hDone)
                pStat_q[curLevel_q] <= 1'b1;
            if (hDone && iackBerr)
                pStat_q[vme_irq_pkg::PS_BERR] <= 1'b1;
            if (softAckEv)
                pStat_q[vme_irq_pkg::PS_SOFTACK] <= 1'b1;
            if (sysfailSync && pEn_q[vme_irq_pkg::PS_SYSFAIL])
                pStat_q[vme_irq_pkg::PS_SYSFAIL] <= 1'b1;
            if (acfailSync && pEn_q[vme_irq_pkg::PS_ACFAIL])
                pStat_q[vme_irq_pkg::PS_ACFAIL] <= 1'b1;
        end
    end

    // Mapped PCI outputs; an enabled status bit drives its chosen line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pciIrqOut_q <= 8'h0;
        end else begin
            pciIrqOut_q <= 8'h0;
            for (int s = 1; s <= 11; s++) begin
                if (pStat_q[s] && pEn_q[s]) begin
                    if (s <= 7)
                        pciIrqOut_q[pMap_q[s*3 +: 3]] <= 1'b1;
                    else
                        pciIrqOut_q[pMisc_q[(s-8)*3 +: 3]] <= 1'b1;
                end
            end
        end
    end

    assign readdata     = readdata_q;
    assign waitrequest  = !ack_q;
    assign vmeIrqOut    = vmeIrqOut_q;
    assign vectorOut    = vectorOut_q;
    assign vectorStrobe = vectorStrobe_q;
    assign grantTarget  = grantTarget_q;
    assign grantDma     = grantDma_q;
    assign masterReq    = masterReq_q;
    assign busReqLevel  = mctl_q[1:0];
    assign iackStart    = iackStart_q;
    assign iackLevelOut = curLevel_q;
    assign pciIrqOut    = pciIrqOut_q;

    chk_vector_upper: assert property (@(posedge clk) disable iff (rst)
        vectorStrobe_q |-> vectorOut_q[7:1] == $past(ivec_q))
        else $error("vector upper bits differ from programmed value");
    chk_soft_lsb: assert property (@(posedge clk) disable iff (rst)
        vectorStrobe_q && !vectorOut_q[0] |-> pStat_q[vme_irq_pkg::PS_SOFTACK]
        && !vStat_q[vme_irq_pkg::SOFT_BASE + int'(respLvl_q)])
        else $error("software vector answered but soft status still set");
    chk_roak_release: assert property (@(posedge clk) disable iff (rst)
        softAckEv |=> pStat_q[vme_irq_pkg::PS_SOFTACK] ##1
        !vmeIrqOut_q[respLvl_q] || vStat_q[7:0] != 8'h0)
        else $error("software level not released after acknowledge");
    chk_local_raise: assert property (@(posedge clk) disable iff (rst)
        (|(localSync & vEn_q[7:0])) |=> (|vStat_q[7:0]))
        else $error("enabled local line did not set status");
    chk_fwd_after_ack_cycle_error_flag: assert property (@(posedge clk) disable iff (rst)
        $rose(|pStat_q[7:1]) |-> $past(hDone))
        else $error("level event without completed acknowledge");
    chk_no_reack: assert property (@(posedge clk) disable iff (rst)
        iackStart_q |-> !pStat_q[curLevel_q] && curLevel_q != 3'h0)
        else $error("acknowledge started on serviced level");
    chk_irq_priority: assert property (@(posedge clk) disable iff (rst)
        masterReq_q && !grantTarget_q && !grantDma_q && !grantIrq_q |=> grantIrq_q)
        else $error("free master not given to interrupt channel");
    chk_berr_logs: assert property (@(posedge clk) disable iff (rst)
        hDone && iackBerr |=> amErr_q && pStat_q[vme_irq_pkg::PS_BERR]
        && pStat_q[$past(curLevel_q)] && lvec_q[$past(curLevel_q)][vme_irq_pkg::LVEC_ERR])
        else $error("acknowledge bus error not logged");
    cov_soft_ack: cover property (@(posedge clk) disable iff (rst) softAckEv);
    cov_ack_cycle_error_flag_ok: cover property (@(posedge clk) disable iff (rst) hDone && !iackBerr);
    cov_ack_cycle_error_flag_err: cover property (@(posedge clk) disable iff (rst) hDone && iackBerr);
    cov_pci_out: cover property (@(posedge clk) disable iff (rst) |pciIrqOut_q);
endmodule

// ===== tb/vme_master_model.sv
`timescale 1ns/1ps
// Far side master: runs each acknowledge cycle after a chosen delay
module vme_master_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       iackStart,
    input  wire logic [2:0] iackLevelOut,
    input  wire logic       berrMode,
    input  wire logic [3:0] dly,
    output logic            iackDone,
    output logic            iackBerr,
    output logic      [7:0] iackVectorIn
);
    logic [3:0] cnt_q;
    logic [2:0] lvl_q;
    // Vector lines toggle outside the done pulse, so a stale vector never passes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            lvl_q <= 3'h0;
            iackDone <= 1'h0;
            iackBerr <= 1'h0;
            iackVectorIn <= 8'h00;
        end else begin
            iackDone <= 1'h0;
            iackBerr <= 1'h0;
            iackVectorIn <= ~iackVectorIn;
            if (iackStart) begin
                cnt_q <= dly;
                lvl_q <= iackLevelOut;
            end else if (cnt_q == 4'h1) begin
                iackDone <= 1'h1;
                iackBerr <= berrMode;
                iackVectorIn <= {lvl_q, 5'h0B}; // Level in the top bits
                cnt_q <= 4'h0;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule

// ===== tb/test_vme_pci_interrupt_channel.sv
`timescale 1ns/1ps
module test_vme_pci_interrupt_channel;
    logic        clk = 1'h0, rst = 1'h1, read = 1'h0, write = 1'h0, berrMode = 1'h0;
    logic        iackDecoded = 1'h0, iackinN = 1'h1, sysfailIn = 1'h0, acfailIn = 1'h0;
    logic        targetReq = 1'h0, dmaReq = 1'h0, waitrequest, vectorStrobe, grantTarget;
    logic        grantDma, masterReq, iackStart, iackDone, iackBerr, got;
    logic [1:0]  busReqLevel;
    logic [2:0]  iackLevelIn = 3'h0, iackLevelOut, lv;
    logic [3:0]  byteenable = 4'hF, dly = 4'h1;
    logic [7:1]  vmeIrqIn = 7'h00, vmeIrqOut;
    logic [7:0]  address = 8'h00, localIrqLines = 8'h00, vectorOut, iackVectorIn, pciIrqOut, v;
    logic [31:0] writedata = 32'h0, readdata, q;
    int          errCount = 0, nTests = 0, cyc = 0;

    vme_pci_interrupt_channel DUT (.clk, .rst, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .localIrqLines, .vmeIrqIn, .sysfailIn, .acfailIn, .iackDecoded,
        .iackLevelIn, .iackinN, .vmeIrqOut, .vectorOut, .vectorStrobe, .targetReq, .dmaReq,
        .grantTarget, .grantDma, .masterReq, .busReqLevel, .iackStart, .iackLevelOut, .iackDone,
        .iackBerr, .iackVectorIn, .pciIrqOut);
    vme_master_model farSide (.clk, .rst, .iackStart, .iackLevelOut, .berrMode, .dly, .iackDone,
        .iackBerr, .iackVectorIn);

    // Clock, and a watchdog so a hung handshake still ends the run
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            errCount++;
            print_verdict();
        end
    end

    task print_verdict();
        $display("Checks %0d, errors %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One access, held until waitrequest is sampled low; an idle edge follows the release
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'h0);
        q = readdata;
        read <= 1'h0;
        write <= 1'h0;
        @(posedge clk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(q, e);
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Remote handler acknowledges level l; catches the one-cycle vector strobe
    task ack_cycle_error_flag(input logic [2:0] l, input logic inN);
        iackLevelIn <= l;
        iackinN <= inN;
        iackDecoded <= 1'h1;
        got = 1'h0;
        repeat (6) begin
            @(posedge clk);
            if (vectorStrobe === 1'h1) begin
                got = 1'h1;
                v = vectorOut;
            end
        end
        iackDecoded <= 1'h0;
        iackinN <= 1'h1;
        tick(3);
    endtask

    // Bounded wait for the next acknowledge request towards the master
    task waitStart();
        int n;
        n = 0;
        got = 1'h0;
        while (!got && n < 40) begin
            @(posedge clk);
            n++;
            if (iackStart === 1'h1) begin
                got = 1'h1;
                lv = iackLevelOut;
            end
        end
    endtask

    // Reset value, unmapped place, requester level
    task regsTest();
        rdchk(8'h00, 32'h0000_00FE);
        rdchk(8'h30, 32'h0);
        wr(8'h20, 32'h2);
        chk(busReqLevel, 32'h2);
        wr(8'h00, 32'hB4);
    endtask

    // Software source: daisy chain, common vector, release on acknowledge
    task softTest();
        wr(8'h04, 32'h400);
        tick(2);
        chk(vmeIrqOut, 32'h04);
        ack_cycle_error_flag(3'h3, 1'h1);
        chk(got, 32'h0);
        ack_cycle_error_flag(3'h2, 1'h0);
        chk(got, 32'h0);
        ack_cycle_error_flag(3'h3, 1'h0);
        chk({got, v}, 32'h1B4);
        chk(vmeIrqOut, 32'h0);
        rdchk(8'h08, 32'h0);
        rdchk(8'h14, 32'h400);
        wr(8'h14, 32'h400);
    endtask

    // Local lines: level zero, soft first, repeat while the line is held
    task roraTest();
        wr(8'h0C, 32'h5);
        wr(8'h04, 32'h3);
        localIrqLines <= 8'h02;
        tick(5);
        chk(vmeIrqOut, 32'h0);
        localIrqLines <= 8'h03;
        tick(5);
        chk(vmeIrqOut, 32'h10);
        wr(8'h04, 32'h1003);
        ack_cycle_error_flag(3'h5, 1'h0);
        chk(v, 32'hB4);
        ack_cycle_error_flag(3'h5, 1'h0);
        chk(v, 32'hB5);
        chk(vmeIrqOut, 32'h10);
        wr(8'h08, 32'h1);
        tick(2);
        bus(1'h0, 8'h08, 32'h0);
        chk(q[0], 32'h1);
        chk(vmeIrqOut, 32'h10);
        localIrqLines <= 8'h00;
        tick(3);
        wr(8'h08, 32'h3);
        tick(2);
        chk(vmeIrqOut, 32'h0);
        wr(8'h04, 32'h0);
        rdchk(8'h14, 32'h400);
        wr(8'h14, 32'h400);
    endtask

    // Fail line and shared master: fail lines never acknowledged, irq beats dma
    task sideTest();
        wr(8'h10, 32'h302);
        sysfailIn <= 1'h1;
        dmaReq <= 1'h1;
        targetReq <= 1'h1;
        tick(5);
        chk(pciIrqOut, 32'h01);
        chk({grantDma, grantTarget, masterReq}, 32'h4);
        dmaReq <= 1'h0;
        tick(3);
        chk({grantDma, grantTarget}, 32'h1);
        vmeIrqIn <= 7'h01;
        dmaReq <= 1'h1;
        tick(5);
        targetReq <= 1'h0;
        waitStart();
        chk({got, lv, grantDma}, 32'h12);
        vmeIrqIn <= 7'h00;
        sysfailIn <= 1'h0;
        dmaReq <= 1'h0;
        tick(20);
        rdchk(8'h14, 32'h102);
        wr(8'h14, 32'h102);
    endtask

    // Handler: first detected level wins, forwarding only after completion
    task handlerTest();
        wr(8'h10, 32'h44);
        wr(8'h18, 32'h0010_0040);
        dly <= 4'h9;
        vmeIrqIn <= 7'h02;
        tick(1);
        vmeIrqIn <= 7'h22;
        waitStart();
        chk({got, lv}, 32'hA);
        chk(masterReq, 32'h1);
        chk(pciIrqOut, 32'h0);
        waitStart();
        chk({got, lv}, 32'hE);
        tick(14);
        chk(pciIrqOut, 32'h12);
        rdchk(8'h48, 32'h4B);
        rdchk(8'h58, 32'hCB);
        waitStart();
        chk(got, 32'h0);
        vmeIrqIn <= 7'h00;
        tick(3);
        wr(8'h14, 32'h4);
        tick(1);
        chk(pciIrqOut, 32'h10);
        wr(8'h14, 32'h40);
    endtask

    // Bus error on both fetches: logs, flag, level and error events together
    task berrTest();
        berrMode <= 1'h1;
        dly <= 4'h1;
        wr(8'h10, 32'h888);
        wr(8'h18, 32'h0040_0000);
        vmeIrqIn <= 7'h44;
        waitStart();
        chk({got, lv}, 32'hF);
        waitStart();
        chk({got, lv}, 32'hB);
        tick(6);
        rdchk(8'h14, 32'h888);
        chk(pciIrqOut, 32'h05);
        rdchk(8'h5C, 32'h1EB);
        rdchk(8'h24, 32'h1);
        rdchk(8'h28, 32'h1B);
        vmeIrqIn <= 7'h00;
        berrMode <= 1'h0;
    endtask

    // Main sequence
    initial begin
        tick(4);
        rst <= 1'h0;
        tick(1);
        regsTest();
        softTest();
        roraTest();
        handlerTest();
        sideTest();
        berrTest();
        print_verdict();
    end
endmodule
